// ==== src/status_event_summary.sv ====
// status byte summary, standard event latch, parallel poll flag and operation register
`timescale 1ns/1ps
`include "status_event_summary_cfg.svh"

module status_event_summary
  import status_event_summary_pkg::*;
(
  input  wire logic  clk,
  input  wire logic  reset,
  input  wire byte_t status_bits_in,
  input  wire logic  poll_mask_wr,
  input  wire byte_t poll_mask_wdata,
  input  wire logic  event_mask_wr,
  input  wire byte_t event_mask_wdata,
  input  wire logic  event_latch_rd,
  input  wire logic  op_mask_wr,
  input  wire word_t op_mask_wdata,
  input  wire logic  op_event_rd,
  input  wire logic  opc_cmd,
  input  wire logic  cmds_pending,
  input  wire logic  query_err,
  input  wire logic  dev_err,
  input  wire logic  exec_err,
  input  wire logic  cmd_err,
  input  wire logic  go_local,
  input  wire logic  calibrating,
  input  wire logic  sweeping,
  input  wire logic  measuring,
  input  wire logic  trig_waiting,
  input  wire logic  hardcopy_busy,
  input  wire logic  scan_block_ready,
  input  wire logic  continuous_result_feed,
  input  wire logic  range_done,
  input  wire logic  threshold_active,
  output logic       local_summary_flag,
  output byte_t      parallel_poll_mask,
  output byte_t      standard_event_latch,
  output byte_t      standard_event_mask,
  output logic       event_summary_bit,
  output logic       oper_summary_bit,
  output word_t      operation_condition,
  output word_t      operation_activity,
  output word_t      operation_mask
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  byte_t      ppm_ff;
  byte_t      esl_ff;
  byte_t      esm_ff;
  word_t      opc_cond_ff;
  word_t      op_evt_ff;
  word_t      op_mask_ff;
  logic       ist_ff;
  logic       esb_ff;
  logic       oper_ff;
  logic       pwr_pending_ff;
  opc_state_e opc_st_ff;
  opc_state_e nxt_opc_st;

  // bit positions that carry a meaning; the rest read zero in the latches and operation words, not in the event mask
  localparam byte_t STD_USED = `SES_STD_USED_MASK;
  localparam word_t OP_USED  = `SES_OP_USED_MASK;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  // a read strobe becomes the clear pattern of a latch word
  function automatic word_t clear_pattern(input logic rd);
    clear_pattern = rd ? 16'hffff : 16'h0000;
  endfunction

  // any event bit that is set together with its enable bit
  function automatic logic masked_any(input word_t evt, input word_t en);
    masked_any = |(evt & en);
  endfunction

  // ----------------------------------------------------------------
  // operation complete tracking
  // ----------------------------------------------------------------
  wire logic opc_fire = (opc_st_ff == OPC_ARMED) && !cmds_pending;

  always_comb
  begin
    nxt_opc_st = opc_st_ff;
    unique case (opc_st_ff)
      OPC_IDLE:  if (opc_cmd) nxt_opc_st = OPC_ARMED;
      OPC_ARMED: if (opc_fire) nxt_opc_st = OPC_DONE;
      OPC_DONE:  nxt_opc_st = opc_cmd ? OPC_ARMED : OPC_IDLE;
      default:   nxt_opc_st = OPC_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // standard event sources
  // ----------------------------------------------------------------
  byte_t std_set;
  always_comb
  begin
    std_set = 8'h00;
    std_set[`SES_BIT_OPC]       = opc_fire;
    std_set[`SES_BIT_QUERY_ERR] = query_err;
    std_set[`SES_BIT_DEV_ERR]   = dev_err;
    std_set[`SES_BIT_EXEC_ERR]  = exec_err;
    std_set[`SES_BIT_CMD_ERR]   = cmd_err;
    std_set[`SES_BIT_USER_REQ]  = go_local;
    std_set[`SES_BIT_POWER_ON]  = pwr_pending_ff;
  end

  // read clears the latch; a set arriving in the same cycle wins, so an
  // event that lands on the read edge is reported by the next read
  wire byte_t std_clr = byte_t'(clear_pattern(event_latch_rd));
  wire byte_t nxt_esl;
  wire byte_t esl_rise;

  for (genvar i = 0; i < 8; i++)
  begin : g_std_bit
    // bit 1 has no source and stays at zero
    assign nxt_esl[i]  = ((esl_ff[i] & ~std_clr[i]) | std_set[i]) & STD_USED[i];
    assign esl_rise[i] = nxt_esl[i] & ~esl_ff[i];
  end

  // ----------------------------------------------------------------
  // event summary bit
  // ----------------------------------------------------------------
  // the summary is the level of latched and enabled bits; a fresh rise
  // is always part of that level, so no rising edge is ever missed
  wire byte_t nxt_esm   = event_mask_wr ? event_mask_wdata : esm_ff;
  wire logic  esb_level = masked_any({8'h00, nxt_esl}, {8'h00, nxt_esm});
  wire logic  esb_rise  = masked_any({8'h00, esl_rise}, {8'h00, nxt_esm});
  wire logic  nxt_esb   = esb_level | esb_rise;

  // ----------------------------------------------------------------
  // operation register
  // ----------------------------------------------------------------
  word_t op_cond;
  always_comb
  begin
    op_cond = 16'h0000;
    op_cond[`SES_OP_CAL]        = calibrating;
    op_cond[`SES_OP_SWEEP]      = sweeping | measuring;
    op_cond[`SES_OP_MEAS]       = sweeping | measuring;
    op_cond[`SES_OP_TRIG_WAIT]  = trig_waiting;
    op_cond[`SES_OP_HARDCOPY]   = hardcopy_busy;
    op_cond[`SES_OP_SCAN_AVAIL] = scan_block_ready & continuous_result_feed;
    op_cond[`SES_OP_RANGE_DONE] = range_done;
    op_cond[`SES_OP_THRESHOLD]  = threshold_active;
  end

  // events latch any activity seen until the controller reads them; the
  // live bits are kept apart so a poll can tell running from finished work
  wire word_t op_cond_m = op_cond & OP_USED;
  wire word_t op_clr    = clear_pattern(op_event_rd);
  wire word_t nxt_op_evt;

  for (genvar j = 0; j < 16; j++)
  begin : g_op_bit
    // a condition that is high on the read edge survives the clear
    assign nxt_op_evt[j] = (op_evt_ff[j] & ~op_clr[j]) | op_cond_m[j];
  end

  // ----------------------------------------------------------------
  // operation summary bit
  // ----------------------------------------------------------------
  // unused positions of the mask cannot be set, so they never hide a bit
  wire word_t nxt_op_mask = op_mask_wr ? (op_mask_wdata & OP_USED) : op_mask_ff;
  wire logic  nxt_oper    = masked_any(nxt_op_evt, nxt_op_mask);

  // ----------------------------------------------------------------
  // status byte and parallel poll flag
  // ----------------------------------------------------------------
  // bits 5 and 7 are produced here; bit 6 and the rest come from outside
  wire byte_t nxt_ppm = poll_mask_wr ? poll_mask_wdata : ppm_ff;
  byte_t      stb;

  always_comb
  begin
    stb                = status_bits_in;
    stb[`SES_STB_ESB]  = nxt_esb;
    stb[`SES_STB_OPER] = nxt_oper;
  end

  // every bit of the byte may take part, bit 6 included
  wire logic nxt_ist = masked_any({8'h00, stb}, {8'h00, nxt_ppm});

  // ----------------------------------------------------------------
  // mask registers
  // ----------------------------------------------------------------
  // masks keep their value until rewritten; reads do not disturb them
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ppm_ff     <= `SES_MASK_RESET;
      esm_ff     <= `SES_MASK_RESET;
      op_mask_ff <= `SES_OP_MASK_RESET;
    end
    else
    begin
      ppm_ff     <= nxt_ppm;
      esm_ff     <= nxt_esm;
      op_mask_ff <= nxt_op_mask;
    end
  end

  // ----------------------------------------------------------------
  // event latches and the registered live operation condition
  // ----------------------------------------------------------------
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      esl_ff      <= 8'h00;
      opc_cond_ff <= 16'h0000;
      op_evt_ff   <= 16'h0000;
    end
    else
    begin
      esl_ff      <= nxt_esl;
      opc_cond_ff <= op_cond_m;
      op_evt_ff   <= nxt_op_evt;
    end
  end

  // ----------------------------------------------------------------
  // power on and operation complete
  // ----------------------------------------------------------------
  // the power on bit is raised by the first clock after reset, so a
  // reset in mid-run reports itself like a fresh power up
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      pwr_pending_ff <= 1'b1;
      opc_st_ff      <= OPC_IDLE;
    end
    else
    begin
      pwr_pending_ff <= 1'b0;
      opc_st_ff      <= nxt_opc_st;
    end
  end

  // ----------------------------------------------------------------
  // summary flags
  // ----------------------------------------------------------------
  // the flags come from the next-state words, so they never lag the
  // latches and masks that they summarise
  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      ist_ff  <= 1'b0;
      esb_ff  <= 1'b0;
      oper_ff <= 1'b0;
    end
    else
    begin
      ist_ff  <= nxt_ist;
      esb_ff  <= nxt_esb;
      oper_ff <= nxt_oper;
    end
  end

  // ----------------------------------------------------------------
  // outputs, each straight from a flip-flop
  // ----------------------------------------------------------------
  assign local_summary_flag   = ist_ff;
  assign parallel_poll_mask   = ppm_ff;
  assign standard_event_latch = esl_ff;
  assign standard_event_mask  = esm_ff;
  assign event_summary_bit    = esb_ff;
  assign oper_summary_bit     = oper_ff;
  assign operation_condition  = opc_cond_ff;
  assign operation_activity   = op_evt_ff;
  assign operation_mask       = op_mask_ff;

endmodule

// ==== include/status_event_summary_cfg.svh ====
// offsets, field positions and reset values of the status event summary block
`ifndef STATUS_EVENT_SUMMARY_CFG_SVH
`define STATUS_EVENT_SUMMARY_CFG_SVH
`define SES_BIT_OPC        0
`define SES_BIT_QUERY_ERR  2
`define SES_BIT_DEV_ERR    3
`define SES_BIT_EXEC_ERR   4
`define SES_BIT_CMD_ERR    5
`define SES_BIT_USER_REQ   6
`define SES_BIT_POWER_ON   7
`define SES_STD_USED_MASK  8'hfd
`define SES_OP_USED_MASK   16'h2739
`define SES_OP_CAL         0
`define SES_OP_SWEEP       3
`define SES_OP_MEAS        4
`define SES_OP_TRIG_WAIT   5
`define SES_OP_HARDCOPY    8
`define SES_OP_SCAN_AVAIL  9
`define SES_OP_RANGE_DONE  10
`define SES_OP_THRESHOLD   13
`define SES_STB_ESB        5
`define SES_STB_OPER       7
`define SES_MASK_RESET     8'h00
`define SES_OP_MASK_RESET  16'h0000
`endif

// ==== include/status_event_summary_pkg.sv ====
// types shared by the status event summary block
package status_event_summary_pkg;
  typedef logic [7:0]  byte_t;
  typedef logic [15:0] word_t;
  typedef enum logic [2:0]
  {
    OPC_IDLE  = 3'b001,
    OPC_ARMED = 3'b010,
    OPC_DONE  = 3'b100
  } opc_state_e;
endpackage

// ==== tb/status_event_summary_checker.sv ====
// port checker for the status event summary block
`timescale 1ns/1ps
module status_event_summary_checker
  import status_event_summary_pkg::*;
(
  input wire logic  clk,
  input wire logic  reset,
  input wire logic  poll_mask_wr,
  input wire byte_t poll_mask_wdata,
  input wire logic  event_mask_wr,
  input wire byte_t event_mask_wdata,
  input wire logic  dev_err,
  input wire logic  calibrating,
  input wire byte_t parallel_poll_mask,
  input wire byte_t standard_event_latch,
  input wire byte_t standard_event_mask,
  input wire logic  event_summary_bit,
  input wire logic  oper_summary_bit,
  input wire word_t operation_condition,
  input wire word_t operation_activity,
  input wire word_t operation_mask
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  esb_sum_a: assert property (event_summary_bit == |(standard_event_latch & standard_event_mask)) else $error("esb");
  oper_sum_a: assert property (oper_summary_bit == |(operation_activity & operation_mask)) else $error("oper");
  unused_zero_a: assert property (!standard_event_latch[1] && !(operation_activity & 16'hd8c6)
    && !operation_condition[15]) else $error("unused bits");
  ppe_load_a: assert property (poll_mask_wr |=> parallel_poll_mask == $past(poll_mask_wdata)) else $error("ppe");
  ese_load_a: assert property (event_mask_wr |=> standard_event_mask == $past(event_mask_wdata)) else $error("ese");
  dev_err_a: assert property (dev_err |=> standard_event_latch[3]) else $error("dev err");
  cal_live_a: assert property (calibrating |=> operation_condition[0]) else $error("cal");
  sweep_pair_a: assert property (operation_condition[3] == operation_condition[4]) else $error("pair");
  cover property (dev_err ##1 event_summary_bit);
  cover property (oper_summary_bit);
  cover property (calibrating ##1 operation_condition[0]);
endmodule
bind status_event_summary status_event_summary_checker status_event_summary_checker_i (.*);

// ==== tb/controller_model.sv ====
// remote controller issuing common commands as one-edge strobes
`timescale 1ns/1ps
module controller_model
  import status_event_summary_pkg::*;
(
  input wire logic clk,
  output logic     poll_mask_wr,
  output byte_t    poll_mask_wdata,
  output logic     event_mask_wr,
  output byte_t    event_mask_wdata,
  output logic     event_latch_rd,
  output logic     op_mask_wr,
  output word_t    op_mask_wdata,
  output logic     op_event_rd,
  output logic     opc_cmd
);
  logic [5:0] s = '0;
  assign {opc_cmd, op_event_rd, op_mask_wr, event_latch_rd, event_mask_wr, poll_mask_wr} = s;
  initial {op_mask_wdata, event_mask_wdata, poll_mask_wdata} = '0;
  // released data is scrambled so a stale value cannot pass
  task automatic send(input int k, input word_t d);
    @(negedge clk);
    {op_mask_wdata, event_mask_wdata, poll_mask_wdata} = {d, d[7:0], d[7:0]};
    s = 6'h01 << k;
    @(negedge clk);
    s = '0;
    {op_mask_wdata, event_mask_wdata, poll_mask_wdata} = ~{d, d[7:0], d[7:0]};
  endtask
endmodule

// ==== tb/status_event_summary_test.sv ====
// self-checking bench for the status event summary block
`timescale 1ns/1ps
module status_event_summary_test import status_event_summary_pkg::*;;
  logic clk = 0, reset = 1, cmds_pending = 0, query_err = 0, dev_err = 0, exec_err = 0, cmd_err = 0, go_local = 0;
  logic opc_cmd, poll_mask_wr, event_mask_wr, event_latch_rd, op_mask_wr, op_event_rd;
  logic local_summary_flag, event_summary_bit, oper_summary_bit;
  logic [8:0] v = 0;
  wire calibrating, sweeping, measuring, trig_waiting, hardcopy_busy, scan_block_ready, continuous_result_feed;
  wire range_done, threshold_active;
  byte_t status_bits_in = 0, poll_mask_wdata, event_mask_wdata, parallel_poll_mask, standard_event_latch;
  byte_t standard_event_mask;
  word_t op_mask_wdata, operation_condition, operation_activity, operation_mask, d, acc;
  int errors = 0, n_compared = 0, cyc = 0, seed = 32'hb18d5ebc;
  assign {calibrating, sweeping, measuring, trig_waiting, hardcopy_busy, scan_block_ready, continuous_result_feed,
    range_done, threshold_active} = v;
  status_event_summary status_event_summary_i (.*);
  controller_model controller_model_i (.*);
  always #5 clk = ~clk;
  always @(posedge clk) if (++cyc == 3000) begin errors++; stop_test(); end
  task automatic stop_test();
    if (errors == 0 && n_compared > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string nm, input word_t got, input word_t exp);
    n_compared++;
    if (got !== exp) begin errors++; $display("[ERR] %s expected %h seen %h", nm, exp, got); end
  endtask
  // expected live operation bits from the activity levels
  function automatic word_t opx(input logic [8:0] a);
    return {2'b0, a[0], 2'b0, a[1], a[3] & a[2], a[4], 2'b0, a[5], a[7] | a[6], a[7] | a[6], 2'b0, a[8]};
  endfunction
  initial begin
    repeat (2) @(negedge clk);
    reset = 0;
    @(negedge clk);
    chk("power_on", standard_event_latch, 8'h80);
    controller_model_i.send(2, 0);
    chk("latch_clear", standard_event_latch, 0);
    repeat (4) begin
      d = word_t'($random(seed));
      controller_model_i.send(0, d);
      controller_model_i.send(1, d);
      controller_model_i.send(3, d);
      chk("poll_mask", parallel_poll_mask, d[7:0]);
      chk("event_mask", standard_event_mask, d[7:0]);
      chk("op_mask", operation_mask, d & 16'h2739);
    end
    controller_model_i.send(1, 16'hff);
    for (int b = 2; b < 7; b++) begin
      {go_local, cmd_err, exec_err, dev_err, query_err} = 5'h01 << (b - 2);
      @(negedge clk);
      {go_local, cmd_err, exec_err, dev_err, query_err} = '0;
      chk("event_bit", standard_event_latch, 8'h01 << b);
      chk("esb_set", event_summary_bit, 1);
      controller_model_i.send(2, 0);
      chk("esb_clear", event_summary_bit, 0);
    end
    controller_model_i.send(1, 16'hf7);
    dev_err = 1;
    @(negedge clk);
    dev_err = 0;
    chk("esb_masked", event_summary_bit, 0);
    controller_model_i.send(2, 0);
    cmds_pending = 1;
    controller_model_i.send(5, 0);
    repeat (3) @(negedge clk);
    chk("opc_wait", standard_event_latch, 0);
    cmds_pending = 0;
    @(negedge clk);
    chk("opc_done", standard_event_latch, 1);
    controller_model_i.send(3, 16'hffff);
    acc = 0;
    repeat (12) begin
      v = 9'($random(seed));
      repeat (2) @(negedge clk);
      acc |= opx(v);
      chk("op_live", operation_condition, opx(v));
      chk("op_sticky", operation_activity, acc);
      chk("op_summary", oper_summary_bit, |acc);
    end
    v = 0;
    repeat (2) @(negedge clk);
    controller_model_i.send(4, 0);
    chk("op_clear", operation_activity, 0);
    chk("op_sum_clear", oper_summary_bit, 0);
    reset = 1;
    @(negedge clk);
    reset = 0;
    @(negedge clk);
    chk("reset_power_on", standard_event_latch, 8'h80);
    chk("reset_masks", {parallel_poll_mask, standard_event_mask}, 0);
    controller_model_i.send(2, 0);
    for (int k = 0; k < 8; k++) begin
      status_bits_in = byte_t'($random(seed));
      controller_model_i.send(0, 16'h0001 << k);
      @(negedge clk);
      chk("local_flag", local_summary_flag, status_bits_in[k] & (k != 5 && k != 7));
    end
    controller_model_i.send(1, 16'h0004);
    query_err = 1;
    controller_model_i.send(0, 16'h0020);
    query_err = 0;
    chk("flag_esb", local_summary_flag, 1);
    controller_model_i.send(2, 0);
    v = 9'h010;
    controller_model_i.send(3, 16'h0100);
    controller_model_i.send(0, 16'h0080);
    chk("flag_oper", local_summary_flag, 1);
    stop_test();
  end
endmodule
